/* File: verif/cfg_host_model.sv */
`timescale 1ns/100ps
module cfg_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [8:0] o_addr,
    output logic      [7:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 9'h000;
        o_wdata = 8'h00;
    end
    // strobe held across one rising edge, dropped at the next falling one
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_addr  = a;
        o_wdata = d;
        o_wr_en = 1'b1;
        @(negedge i_core_clk);
        o_wr_en = 1'b0;
        o_wdata = ~d; // idle bus must not look like the last value
    endtask
    // read data sampled a full cycle later; it holds until the next read
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_addr  = a;
        o_rd_en = 1'b1;
        @(negedge i_core_clk);
        o_rd_en = 1'b0;
        o_addr  = ~a;
        @(negedge i_core_clk);
        d = i_rdata;
    endtask
endmodule

/* File: verif/tb_cfg_bank.sv */
`timescale 1ns/100ps
module tb_cfg_bank;
    import cfg_bank_pkg::*;
    logic       clk, rst, wr_en, rd_en, fuse, ld, ld2, irq, lp, rreq, pg;
    logic [8:0] addr;
    logic [7:0] wdata, rdata, r, ohost, ofb;
    link_cfg_t  lc;
    power_cfg_t pc;
    logic       io, io_oe, ro, ro_oe, fo, fo_oe;
    int         fails, n_checks;

    cfg_host_model host (.i_core_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
    cfg_bank uut (.i_core_clk(clk), .i_rst(rst), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .i_application_lock_fuse(fuse), .i_otp_load(ld),
        .i_otp_second_read(ld2), .i_otp_port_format(8'h00),
        .i_otp_host_port(ohost), .i_otp_thresh(8'h00),
        .i_otp_buck_phase(8'h00), .i_otp_fb_rst_irq(ofb),
        .i_otp_auto_one(8'h00), .i_irq_event(irq), .i_low_power_mode(lp),
        .i_reset_request(rreq), .i_power_good(pg), .o_link_cfg(lc),
        .o_power_cfg(pc), .o_interrupt_out(io), .o_interrupt_out_oe(io_oe),
        .o_reset_out(ro), .o_reset_out_oe(ro_oe), .o_feedback_two(fo),
        .o_feedback_two_oe(fo_oe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
        host.rd(a, r);
        chk_byte(r, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic otp_pulse();
        @(negedge clk);
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
    endtask
    task automatic close_out();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic t_reset();
        for (int a = 0; a < 6; a++) rchk(ADDR_PORT_FORMAT + a[8:0], 8'h00);
        chk_bit(ro, 1'b1);
        chk_bit(io, 1'b1);
    endtask
    task automatic t_link();
        // unlocked part: link type bit is writable too
        host.wr(ADDR_HOST_PORT, 8'hff);
        rchk(ADDR_HOST_PORT, 8'hff);
        chk_bit(lc.main_link_fast_continuous, 1'b1);
        chk_bit(lc.main_link_fastplus, 1'b1);
        chk_bit(lc.link_is_two_wire, 1'b1);
        for (int v = 0; v < 4; v++) begin
            host.wr(ADDR_PORT_FORMAT, v[7:0]);
            chk_bit(lc.clock_idle_level, v[1]);
            chk_bit(lc.select_sense_high, v[0]);
        end
    endtask
    task automatic t_lock();
        fuse = 1'b1;
        host.wr(ADDR_PORT_FORMAT, 8'h00);
        rchk(ADDR_PORT_FORMAT, 8'h03);
        host.wr(ADDR_HOST_PORT, 8'h00);
        rchk(ADDR_HOST_PORT, 8'h93);
        chk_bit(lc.main_link_fast_continuous, 1'b0);
        // fused image still loads while locked
        ohost = 8'h11;
        otp_pulse();
        rchk(ADDR_HOST_PORT, 8'h11);
        rchk(ADDR_PORT_FORMAT, 8'h00);
        chk_bit(lc.link_is_two_wire, 1'b0);
        host.wr(ADDR_HOST_PORT, 8'hff);
        rchk(ADDR_HOST_PORT, 8'h7d);
        chk_bit(lc.link_is_two_wire, 1'b0);
        fuse = 1'b0;
    endtask
    task automatic t_thresh();
        host.wr(ADDR_FAULT_THRESH, 8'hff);
        rchk(ADDR_FAULT_THRESH, 8'h7f);
        chk_byte(8'(pc.fault_hysteresis_code), 8'h07);
        chk_byte(8'(pc.fault_threshold_code), 8'h0f);
        host.wr(ADDR_FAULT_THRESH, 8'h80);
        chk_byte({1'b0, pc.fault_hysteresis_code, pc.fault_threshold_code},
                 8'h00);
    endtask
    task automatic t_buck();
        // processor buck inverted, memory buck normal: opposite phases
        host.wr(ADDR_BUCK_PHASE, 8'h1c);
        chk_byte(8'(pc.buck_phase_invert), 8'h03);
        chk_bit(pc.core2_phase_invert, 1'b0);
        chk_bit(pc.rail_active_discharge, 1'b1);
        for (int f = 0; f < 4; f++) begin
            host.wr(ADDR_BUCK_PHASE, f[7:0]);
            chk_byte(8'(pc.first_ldo_follow_select), f[7:0]);
            chk_bit(pc.core2_phase_invert, 1'b1);
            chk_bit(pc.rail_active_discharge, 1'b0);
        end
    endtask
    task automatic t_pins();
        host.wr(ADDR_HOST_PORT, 8'h00);
        irq = 1'b1;
        cyc(2);
        chk_bit(io, 1'b0);
        chk_bit(io_oe, 1'b1);
        host.wr(ADDR_HOST_PORT, 8'h08);
        chk_bit(io, 1'b1);
        host.wr(ADDR_HOST_PORT, 8'h04);
        chk_bit(io_oe & ~io, 1'b1);
        irq = 1'b0;
        cyc(2);
        chk_bit(io_oe, 1'b0);
        chk_bit(ro_oe, 1'b0);
        host.wr(ADDR_FB_RST_IRQ, 8'h20);
        chk_bit(ro_oe & ~ro, 1'b1);
        host.wr(ADDR_FB_RST_IRQ, 8'h00);
        chk_bit(ro_oe, 1'b0);
    endtask
    task automatic t_lowpower();
        host.wr(ADDR_HOST_PORT, 8'h00);
        host.wr(ADDR_FB_RST_IRQ, 8'h02);
        lp = 1'b1;
        irq = 1'b1;
        cyc(3);
        chk_bit(io, 1'b1);
        lp = 1'b0;
        cyc(2);
        chk_bit(io, 1'b0);
        irq = 1'b0;
        host.wr(ADDR_FB_RST_IRQ, 8'h00);
        lp = 1'b1;
        irq = 1'b1;
        cyc(2);
        chk_bit(io, 1'b0);
        irq = 1'b0;
        lp = 1'b0;
    endtask
    task automatic t_fb2();
        for (int s = 0; s < 2; s++) begin
            host.wr(ADDR_FB_RST_IRQ, s ? 8'h40 : 8'h00);
            pg = 1'b1;
            cyc(1);
            chk_bit(fo_oe, s ? 1'b0 : 1'b1);
            if (s == 0) chk_bit(fo, 1'b0);
            pg = 1'b0;
            cyc(1);
            chk_bit(fo_oe, 1'b1);
            chk_bit(fo, s ? 1'b0 : 1'b1);
        end
    endtask
    task automatic t_misc();
        host.wr(ADDR_FB_RST_IRQ, 8'h1c);
        chk_bit(lc.second_link_fast_continuous, 1'b1);
        chk_bit(lc.second_link_fastplus, 1'b1);
        ofb = 8'h00;
        ld2 = 1'b1;
        otp_pulse();
        rchk(ADDR_FB_RST_IRQ, 8'h04);
        chk_bit(pc.system_enable_keep, 1'b1);
        ld2 = 1'b0;
        otp_pulse();
        rchk(ADDR_FB_RST_IRQ, 8'h00);
        host.wr(ADDR_AUTO_ONE, 8'ha5);
        rchk(ADDR_AUTO_ONE, 8'ha5);
        chk_byte(pc.startup_auto, 8'ha5);
        host.wr(9'h10b, 8'hff);
        rchk(9'h10b, 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b1;
        {fuse, ld, ld2, irq, lp, rreq, pg} = 7'h00;
        ohost = 8'h00;
        ofb = 8'h00;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_link();
        t_lock();
        t_thresh();
        t_buck();
        t_pins();
        t_lowpower();
        t_fb2();
        t_misc();
        close_out();
    end
endmodule

/* File: verilog/cfg_bank.sv */
`timescale 1ns/100ps
module cfg_bank
    import cfg_bank_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [8:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    input  wire logic       i_application_lock_fuse,
    input  wire logic       i_otp_load,
    input  wire logic       i_otp_second_read,
    input  wire logic [7:0] i_otp_port_format,
    input  wire logic [7:0] i_otp_host_port,
    input  wire logic [7:0] i_otp_thresh,
    input  wire logic [7:0] i_otp_buck_phase,
    input  wire logic [7:0] i_otp_fb_rst_irq,
    input  wire logic [7:0] i_otp_auto_one,
    input  wire logic       i_irq_event,
    input  wire logic       i_low_power_mode,
    input  wire logic       i_reset_request,
    input  wire logic       i_power_good,
    output link_cfg_t       o_link_cfg,
    output power_cfg_t      o_power_cfg,
    output logic            o_interrupt_out,
    output logic            o_interrupt_out_oe,
    output logic            o_reset_out,
    output logic            o_reset_out_oe,
    output logic            o_feedback_two,
    output logic            o_feedback_two_oe
);

    logic [7:0] port_format_q, port_format_d;
    logic [7:0] host_port_q,   host_port_d;
    logic [7:0] thresh_q,      thresh_d;
    logic [7:0] buck_phase_q,  buck_phase_d;
    logic [7:0] fb_rst_irq_q,  fb_rst_irq_d;
    logic [7:0] auto_one_q,    auto_one_d;
    logic       irq_pend_q,    irq_pend_d;
    logic       irq_line;
    logic       reset_low_n;

    // merge write data into the writable bits only
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // register next-state
    always_comb begin
        port_format_d = port_format_q;
        host_port_d   = host_port_q;
        thresh_d      = thresh_q;
        buck_phase_d  = buck_phase_q;
        fb_rst_irq_d  = fb_rst_irq_q;
        auto_one_d    = auto_one_q;
        if (i_otp_load) begin
            // fused image reloads everything, except a held system enable on the second read
            port_format_d = i_otp_port_format;
            host_port_d   = i_otp_host_port;
            thresh_d      = i_otp_thresh & MASK_THRESH_RW;
            buck_phase_d  = i_otp_buck_phase;
            fb_rst_irq_d  = i_otp_fb_rst_irq;
            auto_one_d    = i_otp_auto_one;
            if (i_otp_second_read && fb_rst_irq_q[BIT_SYSEN_KEEP]) begin
                fb_rst_irq_d[BIT_SYSEN_KEEP] = 1'b1;
            end
        end else if (i_wr_en) begin
            unique case (i_addr)
                ADDR_PORT_FORMAT: begin
                    // read-only to the host once fused; unlocked parts
                    // accept the format bits
                    if (!i_application_lock_fuse) begin
                        port_format_d = i_wdata;
                    end
                end
                ADDR_HOST_PORT: begin
                    // locked parts keep link type and format fixed, silently
                    host_port_d = merge(host_port_q, i_wdata,
                        i_application_lock_fuse ? MASK_HOST_LOCKED
                            : MASK_HOST_PORT_RW);
                    if (!i_application_lock_fuse) begin
                        host_port_d[BIT_LINK_TYPE] = i_wdata[BIT_LINK_TYPE];
                    end
                end
                ADDR_FAULT_THRESH: thresh_d = merge(thresh_q, i_wdata,
                                                    MASK_THRESH_RW);
                ADDR_BUCK_PHASE:   buck_phase_d = i_wdata;
                ADDR_FB_RST_IRQ:   fb_rst_irq_d = i_wdata;
                ADDR_AUTO_ONE:     auto_one_d   = i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            port_format_q <= RST_PORT_FORMAT;
            host_port_q   <= RST_HOST_PORT;
            thresh_q      <= RST_FAULT_THRESH;
            buck_phase_q  <= RST_BUCK_PHASE;
            fb_rst_irq_q  <= RST_FB_RST_IRQ;
            auto_one_q    <= RST_AUTO_ONE;
        end else begin
            port_format_q <= port_format_d;
            host_port_q   <= host_port_d;
            thresh_q      <= thresh_d;
            buck_phase_q  <= buck_phase_d;
            fb_rst_irq_q  <= fb_rst_irq_d;
            auto_one_q    <= auto_one_d;
        end
    end

    // read data, registered; unmapped addresses read zero
    logic [7:0] rdata_d;
    always_comb begin
        unique case (i_addr)
            ADDR_PORT_FORMAT:  rdata_d = port_format_q;
            ADDR_HOST_PORT:    rdata_d = host_port_q;
            ADDR_FAULT_THRESH: rdata_d = thresh_q;
            ADDR_BUCK_PHASE:   rdata_d = buck_phase_q;
            ADDR_FB_RST_IRQ:   rdata_d = fb_rst_irq_q;
            ADDR_AUTO_ONE:     rdata_d = auto_one_q;
            default:           rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd_en) begin
            o_rdata <= rdata_d;
        end
    end

    // configuration fan-out
    always_comb begin
        o_link_cfg.link_is_two_wire =
            host_port_q[BIT_LINK_TYPE];
        o_link_cfg.main_link_fast_continuous =
            host_port_q[BIT_MAIN_HSM];
        o_link_cfg.main_link_fastplus =
            host_port_q[BIT_MAIN_FMP];
        o_link_cfg.clock_idle_level =
            port_format_q[BIT_CLK_IDLE];
        o_link_cfg.select_sense_high =
            port_format_q[BIT_SELECT_SENSE];
        o_link_cfg.second_link_fast_continuous =
            fb_rst_irq_q[BIT_SECOND_HSM];
        o_link_cfg.second_link_fastplus =
            fb_rst_irq_q[BIT_SECOND_FMP];
        o_power_cfg.fault_hysteresis_code = thresh_q[6:4];
        o_power_cfg.fault_threshold_code  = thresh_q[3:0];
        o_power_cfg.buck_phase_invert     = buck_phase_q[7:3];
        // core two is always opposite core one
        o_power_cfg.core2_phase_invert =
            ~buck_phase_q[BIT_CORE1_INV];
        o_power_cfg.rail_active_discharge =
            buck_phase_q[BIT_DISCHARGE];
        o_power_cfg.first_ldo_follow_select =
            buck_phase_q[1:0];
        o_power_cfg.startup_auto = auto_one_q;
        o_power_cfg.system_enable_keep = fb_rst_irq_q[BIT_SYSEN_KEEP];
    end

    // events in low-power modes are masked, not held for active mode, when deferral is set
    always_comb begin
        irq_pend_d = i_irq_event;
        if (fb_rst_irq_q[BIT_IRQ_TIMING] && i_low_power_mode) begin
            irq_pend_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_pend_q <= 1'b0;
        end else begin
            irq_pend_q <= irq_pend_d;
        end
    end

    assign irq_line = irq_pend_q;

    // reset output is low-active; push-pull drives both levels,
    // open drain only pulls low
    assign reset_low_n = ~(i_reset_request |
                           fb_rst_irq_q[BIT_FORCE_RST]);
    always_comb begin
        o_reset_out    = reset_low_n;
        o_reset_out_oe = host_port_q[BIT_DRV_STYLE] ? ~reset_low_n
                                                    : 1'b1;
        o_interrupt_out = host_port_q[BIT_IRQ_POL] ? irq_line
                                                   : ~irq_line;
        // open drain only ever pulls low
        o_interrupt_out_oe = host_port_q[BIT_DRV_STYLE]
                           ? ~o_interrupt_out : 1'b1;
        o_feedback_two    = fb_rst_irq_q[BIT_FB2_STYLE] ? i_power_good
                                                        : ~i_power_good;
        o_feedback_two_oe = fb_rst_irq_q[BIT_FB2_STYLE]
                          ? ~o_feedback_two : 1'b1;
    end

    property p_force_reset;
        @(posedge i_core_clk) disable iff (i_rst)
        fb_rst_irq_q[BIT_FORCE_RST] |-> !o_reset_out && o_reset_out_oe;
    endproperty
    a_force_reset: assert property (p_force_reset)
        else $error("forced reset not driven low");

    property p_lock_port;
        @(posedge i_core_clk) disable iff (i_rst)
        i_application_lock_fuse && !i_otp_load |=> $stable(port_format_q);
    endproperty
    a_lock_port: assert property (p_lock_port)
        else $error("locked format register changed");

    property p_lock_type;
        @(posedge i_core_clk) disable iff (i_rst)
        i_application_lock_fuse && !i_otp_load |=>
            $stable(host_port_q[BIT_LINK_TYPE]);
    endproperty
    a_lock_type: assert property (p_lock_type)
        else $error("locked link type changed");

    property p_core2_opposite;
        @(posedge i_core_clk) disable iff (i_rst)
        o_power_cfg.core2_phase_invert != buck_phase_q[BIT_CORE1_INV];
    endproperty
    a_core2_opposite: assert property (p_core2_opposite)
        else $error("core bucks share a phase");

    property p_irq_defer;
        @(posedge i_core_clk) disable iff (i_rst)
        fb_rst_irq_q[BIT_IRQ_TIMING] && i_low_power_mode
            |=> !irq_pend_q;
    endproperty
    a_irq_defer: assert property (p_irq_defer)
        else $error("interrupt raised during low power");

    property p_irq_now;
        @(posedge i_core_clk) disable iff (i_rst)
        i_irq_event && !fb_rst_irq_q[BIT_IRQ_TIMING] |=>
            o_interrupt_out == host_port_q[BIT_IRQ_POL];
    endproperty
    a_irq_now: assert property (p_irq_now)
        else $error("interrupt level wrong");

    property p_open_drain;
        @(posedge i_core_clk) disable iff (i_rst)
        host_port_q[BIT_DRV_STYLE] |-> !(o_interrupt_out_oe && o_interrupt_out)
            && !(o_reset_out_oe && o_reset_out);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain output drove high");

    property p_thresh_write;
        @(posedge i_core_clk) disable iff (i_rst)
        i_wr_en && !i_otp_load && i_addr == ADDR_FAULT_THRESH |=>
            o_power_cfg.fault_threshold_code == $past(i_wdata[3:0]) &&
            !thresh_q[7];
    endproperty
    a_thresh_write: assert property (p_thresh_write)
        else $error("threshold write not taken");

    property p_lock_supply;
        @(posedge i_core_clk) disable iff (i_rst)
        i_application_lock_fuse && !i_otp_load |=>
            (host_port_q & ~MASK_HOST_LOCKED) ==
            ($past(host_port_q) & ~MASK_HOST_LOCKED);
    endproperty
    a_lock_supply: assert property (p_lock_supply)
        else $error("locked host port bit changed");

    property p_push_pull;
        @(posedge i_core_clk) disable iff (i_rst)
        !host_port_q[BIT_DRV_STYLE] |-> o_interrupt_out_oe && o_reset_out_oe;
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull output not driven");

    property p_otp_reload;
        @(posedge i_core_clk) disable iff (i_rst)
        i_otp_load && !i_otp_second_read |=>
            fb_rst_irq_q == $past(i_otp_fb_rst_irq);
    endproperty
    a_otp_reload: assert property (p_otp_reload)
        else $error("first fuse read not loaded");

    property p_auto_write;
        @(posedge i_core_clk) disable iff (i_rst)
        i_wr_en && !i_otp_load && i_addr == ADDR_AUTO_ONE |=>
            o_power_cfg.startup_auto == $past(i_wdata);
    endproperty
    a_auto_write: assert property (p_auto_write)
        else $error("startup auto write not taken");

endmodule

/* File: verilog/cfg_bank_pkg.sv */
package cfg_bank_pkg;

    // register addresses (9-bit register space)
    localparam logic [8:0] ADDR_PORT_FORMAT  = 9'h105;
    localparam logic [8:0] ADDR_HOST_PORT    = 9'h106;
    localparam logic [8:0] ADDR_FAULT_THRESH = 9'h107;
    localparam logic [8:0] ADDR_BUCK_PHASE   = 9'h108;
    localparam logic [8:0] ADDR_FB_RST_IRQ   = 9'h109;
    localparam logic [8:0] ADDR_AUTO_ONE     = 9'h10a;

    // field positions
    localparam int BIT_SELECT_SENSE   = 0;
    localparam int BIT_CLK_IDLE       = 1;
    localparam int BIT_LINK_TYPE      = 7;
    localparam int BIT_MAIN_HSM       = 6;
    localparam int BIT_MAIN_FMP       = 5;
    localparam int BIT_IRQ_POL        = 3;
    localparam int BIT_DRV_STYLE      = 2;
    localparam int BIT_DISCHARGE      = 2;
    localparam int BIT_CORE1_INV      = 3;
    localparam int BIT_FB2_STYLE      = 6;
    localparam int BIT_FORCE_RST      = 5;
    localparam int BIT_SECOND_HSM     = 4;
    localparam int BIT_SECOND_FMP     = 3;
    localparam int BIT_SYSEN_KEEP     = 2;
    localparam int BIT_IRQ_TIMING     = 1;

    // writable masks; bit 7 of the threshold register is reserved
    localparam logic [7:0] MASK_HOST_PORT_RW = 8'h7f;
    localparam logic [7:0] MASK_HOST_LOCKED  = 8'h6c;
    localparam logic [7:0] MASK_THRESH_RW    = 8'h7f;

    // reset values, loaded again from fuses by the otp load strobe
    localparam logic [7:0] RST_PORT_FORMAT  = 8'h00;
    localparam logic [7:0] RST_HOST_PORT    = 8'h00;
    localparam logic [7:0] RST_FAULT_THRESH = 8'h00;
    localparam logic [7:0] RST_BUCK_PHASE   = 8'h00;
    localparam logic [7:0] RST_FB_RST_IRQ   = 8'h00;
    localparam logic [7:0] RST_AUTO_ONE     = 8'h00;

    // comparator settings in millivolts
    localparam int HYST_BASE_MV   = 100;
    localparam int THRESH_BASE_MV = 2500;
    localparam int STEP_MV        = 50;

    typedef struct packed {
        logic       main_link_fast_continuous;
        logic       main_link_fastplus;
        logic       second_link_fast_continuous;
        logic       second_link_fastplus;
        logic       link_is_two_wire;
        logic       clock_idle_level;
        logic       select_sense_high;
    } link_cfg_t;

    typedef struct packed {
        logic [2:0] fault_hysteresis_code;
        logic [3:0] fault_threshold_code;
        logic [4:0] buck_phase_invert;
        logic       core2_phase_invert;
        logic       rail_active_discharge;
        logic [1:0] first_ldo_follow_select;
        logic [7:0] startup_auto;
        logic       system_enable_keep;
    } power_cfg_t;

endpackage
